// ### rtl/tgr_map.svh
// register offsets, field positions and reset values of the timer general registers
`ifndef TGR_MAP_SVH
`define TGR_MAP_SVH
// register indices; byte address is four times the index
`define TGR_IDX_CH0_A    20'hF0278
`define TGR_IDX_CH0_B    20'hF027A
`define TGR_IDX_CH1_A    20'hF0288
`define TGR_IDX_CH1_B    20'hF028A
`define TGR_IDX_CH0_C    20'hFFF58
`define TGR_IDX_CH0_D    20'hFFF5A
`define TGR_IDX_CH1_C    20'hFFF5C
`define TGR_IDX_CH1_D    20'hFFF5E
`define TGR_IDX_CTRL     20'hFFF60
`define TGR_IDX_AUX      20'hFFF61
`define TGR_IDX_STATUS   20'hFFF62
`define TGR_IDX_MASK     20'hFFF63
`define TGR_IDX_COUNT    20'hFFF64
// reset values
`define TGR_RST_GR       16'hFFFF
`define TGR_RST_CTRL     16'h0000
`define TGR_RST_AUX      16'h0000
`define TGR_RST_MASK     8'h00
// control register fields
`define TGR_CTRL_MODE_LSB 0
`define TGR_CTRL_START0  3
`define TGR_CTRL_START1  4
`define TGR_CTRL_CS_LSB  5
`define TGR_CTRL_BUF_LSB 8
// aux register fields
`define TGR_AUX_IO3_LSB  0
`define TGR_AUX_LVL_LSB  2
`define TGR_AUX_PMS_LSB  8
// clock select codes
`define TGR_CS_UNDIV     3'h0
`define TGR_CS_HSOSC     3'h1
`define TGR_CS_DIV2      3'h2
`define TGR_CS_DIV4      3'h3
`define TGR_CS_DIV8      3'h4
`define TGR_CS_DIV32     3'h5
`endif

// ### rtl/tgr_pkg.sv
// types shared by the timer general register block
package tgr_pkg;
  typedef enum logic [2:0] {
    TGR_CAPTURE,
    TGR_COMPARE,
    TGR_PWM,
    TGR_RSPWM,
    TGR_THREE_PH
  } tgr_mode_type;
endpackage : tgr_pkg

// ### rtl/tgr_chan_cnt.sv
// one channel counter with period clear
`timescale 1ns/1ps
`default_nettype none
module tgr_chan_cnt #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // control
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic             clear,
  // state
  output logic [WIDTH-1:0]      count
);
  // count on each tick, wrap to zero at period end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count <= '0;
    end else if (!run) begin
      count <= count;
    end else if (tick && clear) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end
endmodule : tgr_chan_cnt
`default_nettype wire

// ### rtl/tgr_top.sv
// timer general registers: capture, compare and pwm roles of the A to D registers
`timescale 1ns/1ps
`default_nettype none
`include "tgr_map.svh"
module tgr_top
  import tgr_pkg::*;
#(
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [21:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // timer pins, index channel*4 + (A,B,C,D)
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe,
  // clock source option straps
  input  wire logic        hs_osc_option_bit,
  input  wire logic        timer_peripheral_enable,
  // event link and interrupt
  output logic             link_req,
  output logic             irq
);
  // register state
  logic [15:0]  gr_reg [0:7];
  logic [15:0]  ctrl_reg;
  logic [15:0]  aux_reg;
  logic [7:0]   status_reg;
  logic [7:0]   mask_reg;
  logic [7:0]   status_next;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;
  logic [7:0]   pin_out_reg;
  logic [7:0]   pin_oe_reg;
  logic         link_req_reg;
  logic         irq_reg;
  // synchronisers and prescaler
  logic [7:0]   pin_s1_reg;
  logic [7:0]   pin_s2_reg;
  logic [7:0]   pin_s3_reg;
  logic [1:0]   strap_s1_reg;
  logic [1:0]   strap_s2_reg;
  logic [4:0]   presc_reg;
  logic         run0_q_reg;
  // decoded control
  tgr_mode_type mode;
  logic [2:0]   clock_select;
  logic [1:0]   start;
  logic [1:0]   buffer_select_c;
  logic [1:0]   buffer_select_d;
  logic [1:0]   io_select_bit3;
  logic [5:0]   out_level;
  logic [5:0]   pwm_mode_select;
  logic         single_cnt;
  logic         block_ok;
  logic         tick;
  logic [1:0]   run;
  logic [1:0]   clear;
  logic [CW-1:0] cnt [0:1];
  logic [7:0]   rise;
  logic [7:0]   match;
  logic [7:0]   event_hit;
  logic         setup_ph;
  logic         wr_en;
  logic [4:0]   wr_slot;
  logic [4:0]   rd_slot;

  // map an address to a slot: bit 4 valid, 0-7 general, 8-12 own registers
  function automatic logic [4:0] slot_of(input logic [21:0] addr);
    logic [19:0] idx;
    idx = addr[21:2];
    case (idx)
      `TGR_IDX_CH0_A:  slot_of = 5'h10;
      `TGR_IDX_CH0_B:  slot_of = 5'h11;
      `TGR_IDX_CH0_C:  slot_of = 5'h12;
      `TGR_IDX_CH0_D:  slot_of = 5'h13;
      `TGR_IDX_CH1_A:  slot_of = 5'h14;
      `TGR_IDX_CH1_B:  slot_of = 5'h15;
      `TGR_IDX_CH1_C:  slot_of = 5'h16;
      `TGR_IDX_CH1_D:  slot_of = 5'h17;
      `TGR_IDX_CTRL:   slot_of = 5'h18;
      `TGR_IDX_AUX:    slot_of = 5'h19;
      `TGR_IDX_STATUS: slot_of = 5'h1A;
      `TGR_IDX_MASK:   slot_of = 5'h1B;
      `TGR_IDX_COUNT:  slot_of = 5'h1C;
      default:         slot_of = 5'h00;
    endcase
  endfunction : slot_of

  // control field decode
  assign mode            = tgr_mode_type'(ctrl_reg[`TGR_CTRL_MODE_LSB +: 3]);
  assign start           = {ctrl_reg[`TGR_CTRL_START1], ctrl_reg[`TGR_CTRL_START0]};
  assign clock_select    = ctrl_reg[`TGR_CTRL_CS_LSB +: 3];
  assign buffer_select_c = {ctrl_reg[`TGR_CTRL_BUF_LSB+2], ctrl_reg[`TGR_CTRL_BUF_LSB]};
  assign buffer_select_d = {ctrl_reg[`TGR_CTRL_BUF_LSB+3], ctrl_reg[`TGR_CTRL_BUF_LSB+1]};
  // three-phase pwm sees io, level and mode-select settings as cleared
  assign io_select_bit3  = (mode == TGR_THREE_PH) ? 2'b00 : aux_reg[`TGR_AUX_IO3_LSB +: 2];
  assign out_level       = (mode == TGR_THREE_PH) ? 6'h00 : aux_reg[`TGR_AUX_LVL_LSB +: 6];
  assign pwm_mode_select = (mode == TGR_THREE_PH) ? 6'h00 : aux_reg[`TGR_AUX_PMS_LSB +: 6];
  assign single_cnt      = (mode == TGR_RSPWM) || (mode == TGR_THREE_PH);

  // hold the timer while the hs oscillator source is not enabled
  assign block_ok = !(strap_s2_reg[0] && !strap_s2_reg[1]);

  // count tick from the clock select
  always_comb begin
    case (clock_select)
      `TGR_CS_DIV2:  tick = presc_reg[0];
      `TGR_CS_DIV4:  tick = &presc_reg[1:0];
      `TGR_CS_DIV8:  tick = &presc_reg[2:0];
      `TGR_CS_DIV32: tick = &presc_reg;
      default:       tick = 1'b1;
    endcase
  end

  // channel counters; channel 1 idles in the single-counter modes
  for (genvar c = 0; c < 2; c++) begin : g_cnt
    assign run[c]   = start[c] && block_ok && (c == 0 || !single_cnt);
    assign clear[c] = (mode == TGR_PWM || (c == 0 && single_cnt)) && match[4*c];
    tgr_chan_cnt #(
      .WIDTH (CW)
    ) u_cnt (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .run     (run[c]),
      .tick    (tick),
      .clear   (clear[c]),
      .count   (cnt[c])
    );
  end

  // compare matches and capture edges per register
  for (genvar k = 0; k < 8; k++) begin : g_ev
    localparam int CH = k / 4;
    assign match[k] = run[single_cnt ? 0 : CH] && tick
                      && (cnt[single_cnt ? 0 : CH] == gr_reg[k]);
    assign rise[k]  = (mode == TGR_CAPTURE) && pin_s2_reg[k] && !pin_s3_reg[k];
    assign event_hit[k] = (mode == TGR_CAPTURE) ? rise[k] : match[k];
  end

  // apb decode
  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign wr_slot  = slot_of(paddr);
  assign rd_slot  = slot_of(paddr);

  // pin and strap synchronisers, edge history
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_s1_reg   <= 8'h00;
      pin_s2_reg   <= 8'h00;
      pin_s3_reg   <= 8'h00;
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
    end else begin
      pin_s1_reg   <= pin_in;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      strap_s1_reg <= {timer_peripheral_enable, hs_osc_option_bit};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // free-running prescaler
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      presc_reg <= 5'h00;
    end else begin
      presc_reg <= presc_reg + 5'h01;
    end
  end

  // apb answer: data sampled in setup, ready for one access cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !rd_slot[4] || (pstrb[1:0] != 2'h3 && pwrite);
      prdata_reg  <= 32'h0000_0000;
      if (rd_slot[4] && !rd_slot[3]) begin
        prdata_reg[15:0] <= block_ok ? gr_reg[rd_slot[2:0]] : 16'h0000;
      end else begin
        case (rd_slot)
          5'h18:   prdata_reg[15:0] <= ctrl_reg;
          5'h19:   prdata_reg[15:0] <= aux_reg;
          5'h1A:   prdata_reg[7:0]  <= status_reg;
          5'h1B:   prdata_reg[7:0]  <= mask_reg;
          5'h1C:   prdata_reg       <= {cnt[1], cnt[0]};
          default: prdata_reg       <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // control, aux and mask registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= `TGR_RST_CTRL;
      aux_reg  <= `TGR_RST_AUX;
      mask_reg <= `TGR_RST_MASK;
    end else if (wr_en) begin
      case (wr_slot)
        5'h18:   ctrl_reg <= {4'h0, pwdata[11:0]};
        5'h19:   aux_reg  <= {2'h0, pwdata[13:0]};
        5'h1B:   mask_reg <= pwdata[7:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // general registers: software write, capture latch and buffer moves
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int k = 0; k < 8; k++) begin
        gr_reg[k] <= `TGR_RST_GR;
      end
    end else begin
      if (wr_en && wr_slot[4] && !wr_slot[3]) begin
        gr_reg[wr_slot[2:0]] <= pwdata[15:0];
      end
      for (int c = 0; c < 2; c++) begin
        case (mode)
          TGR_CAPTURE: begin
            if (rise[4*c]) begin
              gr_reg[4*c] <= cnt[c];
              if (buffer_select_c[c]) gr_reg[4*c+2] <= gr_reg[4*c];
            end
            if (rise[4*c+1]) begin
              gr_reg[4*c+1] <= cnt[c];
              if (buffer_select_d[c]) gr_reg[4*c+3] <= gr_reg[4*c+1];
            end
            if (rise[4*c+2] && !buffer_select_c[c]) gr_reg[4*c+2] <= cnt[c];
            if (rise[4*c+3] && !buffer_select_d[c]) gr_reg[4*c+3] <= cnt[c];
          end
          TGR_COMPARE: begin
            if (io_select_bit3[c] && buffer_select_c[c] && match[4*c])
              gr_reg[4*c] <= gr_reg[4*c+2];
            if (io_select_bit3[c] && buffer_select_d[c] && match[4*c+1])
              gr_reg[4*c+1] <= gr_reg[4*c+3];
          end
          TGR_PWM: begin
            if (match[4*c] && buffer_select_c[c]) gr_reg[4*c] <= gr_reg[4*c+2];
            if (match[4*c] && buffer_select_d[c]) gr_reg[4*c+1] <= gr_reg[4*c+3];
          end
          TGR_RSPWM, TGR_THREE_PH: begin
            // all buffered pairs reload at the channel 0 period
            if (match[0] && buffer_select_c[c]) gr_reg[4*c] <= gr_reg[4*c+2];
            if (match[0] && buffer_select_d[c]) gr_reg[4*c+1] <= gr_reg[4*c+3];
          end
          default: ;
        endcase
      end
    end
  end

  // pin drive per mode
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_out_reg <= 8'h00;
      pin_oe_reg  <= 8'h00;
    end else begin
      case (mode)
        TGR_CAPTURE: begin
          pin_oe_reg <= 8'h00;
        end
        TGR_COMPARE: begin
          for (int c = 0; c < 2; c++) begin
            pin_oe_reg[4*c +: 4] <= {{2{io_select_bit3[c]}}, 2'b11};
            if (match[4*c] || (!io_select_bit3[c] && !buffer_select_c[c] && match[4*c+2]))
              pin_out_reg[4*c] <= !pin_out_reg[4*c];
            if (match[4*c+1] || (!io_select_bit3[c] && !buffer_select_d[c] && match[4*c+3]))
              pin_out_reg[4*c+1] <= !pin_out_reg[4*c+1];
            if (io_select_bit3[c] && !buffer_select_c[c] && match[4*c+2])
              pin_out_reg[4*c+2] <= !pin_out_reg[4*c+2];
            if (io_select_bit3[c] && !buffer_select_d[c] && match[4*c+3])
              pin_out_reg[4*c+3] <= !pin_out_reg[4*c+3];
          end
        end
        TGR_PWM: begin
          for (int c = 0; c < 2; c++) begin
            // B,C,D go inactive at the period; B, and C,D when unbuffered, go active at their change point
            pin_oe_reg[4*c +: 4] <= {pwm_mode_select[3*c +: 3], 1'b0};
            if (match[4*c]) begin
              pin_out_reg[4*c+1 +: 3] <= ~out_level[3*c +: 3];
            end else begin
              if (match[4*c+1]) pin_out_reg[4*c+1] <= out_level[3*c];
              if (match[4*c+2] && !buffer_select_c[c])
                pin_out_reg[4*c+2] <= out_level[3*c+1];
              if (match[4*c+3] && !buffer_select_d[c])
                pin_out_reg[4*c+3] <= out_level[3*c+2];
            end
          end
        end
        TGR_RSPWM: begin
          // phase pins: positive on B/A, inverted on the partner pin
          pin_oe_reg <= 8'hFE;
          if (match[0]) begin
            pin_out_reg[2] <= !pin_out_reg[2];
            pin_out_reg[1] <= 1'b0;
            pin_out_reg[3] <= 1'b1;
            pin_out_reg[7:4] <= 4'hC;
          end else begin
            if (match[1]) pin_out_reg[3:0] <= {1'b0, pin_out_reg[2], 2'b10};
            if (match[4]) pin_out_reg[6] <= 1'b0;
            if (match[4]) pin_out_reg[4] <= 1'b1;
            if (match[5]) pin_out_reg[7] <= 1'b0;
            if (match[5]) pin_out_reg[5] <= 1'b1;
          end
        end
        TGR_THREE_PH: begin
          pin_oe_reg <= 8'h03;
          if (match[0]) pin_out_reg[0] <= 1'b0;
          else if (match[4]) pin_out_reg[0] <= 1'b1;
          if (match[1]) pin_out_reg[1] <= 1'b0;
          else if (match[5]) pin_out_reg[1] <= 1'b1;
        end
        default: pin_oe_reg <= 8'h00;
      endcase
    end
  end

  // sticky status: set wins over write-one clear
  always_comb begin
    status_next = status_reg;
    if (wr_en && wr_slot == 5'h1A) status_next = status_next & ~pwdata[7:0];
    status_next = status_next | event_hit;
  end

  // status and interrupt
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      status_reg <= 8'h00;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_reg);
    end
  end

  // event link request from the channel 0 A compare
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      run0_q_reg   <= 1'b0;
      link_req_reg <= 1'b0;
    end else begin
      run0_q_reg <= run[0];
      // both undivided sources give a single request at start for compare zero
      if ((clock_select == `TGR_CS_UNDIV || clock_select == `TGR_CS_HSOSC)
          && gr_reg[0] == 16'h0000)
        link_req_reg <= run[0] && !run0_q_reg;
      else
        link_req_reg <= mode != TGR_CAPTURE && match[0];
    end
  end

  // outputs straight from flops
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe  = pin_oe_reg;
  assign link_req = link_req_reg;
  assign irq     = irq_reg;
endmodule : tgr_top
`default_nettype wire

// ### testbench/tgr_props.sv
// port-level checks of the timer general register block
`timescale 1ns/1ps
`default_nettype none
`include "tgr_map.svh"
module tgr_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [21:0] paddr,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and events
  input wire logic [7:0]  pin_out,
  input wire logic        link_req,
  input wire logic        irq
);
  logic [19:0] idx;
  logic        mapped;
  // decoded register index
  assign idx = paddr[21:2];
  assign mapped = idx inside {`TGR_IDX_CH0_A, `TGR_IDX_CH0_B, `TGR_IDX_CH1_A, `TGR_IDX_CH1_B,
    `TGR_IDX_CH0_C, `TGR_IDX_CH0_D, `TGR_IDX_CH1_C, `TGR_IDX_CH1_D, `TGR_IDX_CTRL,
    `TGR_IDX_AUX, `TGR_IDX_STATUS, `TGR_IDX_MASK, `TGR_IDX_COUNT};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held past access");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_strobe_refused: assert property (
    pready && pwrite && pstrb[1:0] != 2'b11 |-> pslverr)
    else $error("partial write accepted");
  a_unmapped_refused: assert property (pready && !mapped |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access accepted");
  a_read_word_clean: assert property (
    pready && !pwrite && mapped |-> !pslverr && (idx == `TGR_IDX_COUNT || prdata[31:16] == 0))
    else $error("bad read of mapped register");
  a_link_one_pulse: assert property (link_req |=> !link_req)
    else $error("event request longer than one cycle");
  a_reset_quiet: assert property ($rose(resetn) |-> pin_out == 8'h00 && !link_req && !irq)
    else $error("outputs active after reset");
  // main scenarios reached
  c_refused: cover property (pready && pslverr);
  c_event: cover property (link_req);
  c_irq: cover property ($rose(irq));
  c_toggle: cover property ($rose(pin_out[2]));
endmodule : tgr_props
bind tgr_top tgr_props u_props (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .link_req(link_req), .irq(irq));
`default_nettype wire

// ### testbench/tgr_pin_model.sv
// far side: capture pulses on timer pins and event link request counting
`timescale 1ns/1ps
`default_nettype none
module tgr_pin_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // requests from the bench
  input  wire logic [7:0] pulse_req,
  // device side
  input  wire logic       link_req,
  output logic [7:0]      pin_in,
  output int              link_count
);
  logic [2:0] hold_reg [8];
  // each pulse stays high four cycles, above the three-cycle minimum width
  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < 8; k++) begin
      if (!resetn) hold_reg[k] <= 3'h0;
      else if (pulse_req[k]) hold_reg[k] <= 3'h4;
      else if (hold_reg[k] != 3'h0) hold_reg[k] <= hold_reg[k] - 3'h1;
    end
  end
  // pin levels, low between pulses
  always_comb begin
    for (int k = 0; k < 8; k++) pin_in[k] = hold_reg[k] != 3'h0;
  end
  // event link side counts requests
  always_ff @(posedge clk_sys) begin
    if (!resetn) link_count <= 0;
    else if (link_req) link_count <= link_count + 1;
  end
endmodule : tgr_pin_model
`default_nettype wire

// ### testbench/tgr_top_bench.sv
// self-checking bench of the timer general register block
`timescale 1ns/1ps
`default_nettype none
`include "tgr_map.svh"
module tgr_top_bench;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [21:0] paddr = 22'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  pulse_req = 8'h0;
  logic        hs_osc_option_bit = 1'b1;
  logic        timer_peripheral_enable = 1'b1;
  logic        link_req;
  logic        irq;
  int          link_count;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        er;
  logic [19:0] gr_idx [8] = '{`TGR_IDX_CH0_A, `TGR_IDX_CH0_B, `TGR_IDX_CH1_A,
    `TGR_IDX_CH1_B, `TGR_IDX_CH0_C, `TGR_IDX_CH0_D, `TGR_IDX_CH1_C, `TGR_IDX_CH1_D};

  always #12.5 clk_sys = ~clk_sys;

  tgr_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .hs_osc_option_bit(hs_osc_option_bit), .timer_peripheral_enable(timer_peripheral_enable),
    .link_req(link_req), .irq(irq));
  tgr_pin_model u_far (.clk_sys(clk_sys), .resetn(resetn), .pulse_req(pulse_req),
    .link_req(link_req), .pin_in(pin_in), .link_count(link_count));

  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, request held until ready is seen
  task automatic apb(input logic wr, input logic [19:0] idx, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [19:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 4'hF);
  endtask : wr

  task automatic rdx(input logic [19:0] idx);
    apb(1'b0, idx, 32'h0, 4'h0);
  endtask : rdx

  task automatic do_reset;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask : do_reset

  // one capture pulse on pin k, then time for synchronising
  task automatic pulse(input int k);
    @(posedge clk_sys);
    pulse_req <= 8'h01 << k;
    @(posedge clk_sys);
    pulse_req <= 8'h00;
    repeat (8) @(posedge clk_sys);
  endtask : pulse

  // reset values, read-back, partial and unmapped accesses
  task automatic t_regs;
    for (int k = 0; k < 8; k++) begin
      rdx(gr_idx[k]);
      chk(rd, 32'h0000FFFF);
      wr(gr_idx[k], 32'h00001111 * (k + 1));
      rdx(gr_idx[k]);
      chk(rd, 32'h00001111 * (k + 1));
    end
    apb(1'b1, `TGR_IDX_CH0_A, 32'h0, 4'h1);
    chk({31'h0, er}, 32'h1);
    rdx(`TGR_IDX_CH0_A);
    chk(rd, 32'h00001111);
    rdx(20'h00010);
    chk({er, rd[30:0]}, 32'h80000000);
  endtask : t_regs

  // capture roles, buffered capture, status, mask and irq
  task automatic t_capture;
    logic [31:0] a1;
    do_reset;
    wr(`TGR_IDX_CTRL, 32'h00000008);
    pulse(0);
    rdx(`TGR_IDX_CH0_A);
    a1 = rd;
    chk({31'h0, a1 < 32'h0000FFFF}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`TGR_IDX_MASK, 32'h00000001);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(`TGR_IDX_STATUS, 32'h00000001);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    pulse(2);
    rdx(`TGR_IDX_CH0_C);
    chk({31'h0, rd > a1 && rd < 32'h0000FFFF}, 32'h1);
    rdx(`TGR_IDX_CH0_A);
    chk(rd, a1);
    wr(`TGR_IDX_CTRL, 32'h00000108);
    pulse(0);
    rdx(`TGR_IDX_CH0_C);
    chk(rd, a1);
    rdx(`TGR_IDX_CH0_A);
    chk({31'h0, rd > a1}, 32'h1);
  endtask : t_capture

  // compare value zero on both undivided sources: one request per start only
  task automatic t_link_once;
    do_reset;
    wr(`TGR_IDX_CH0_A, 32'h00000000);
    wr(`TGR_IDX_CTRL, 32'h00000009);
    repeat (300) @(posedge clk_sys);
    chk(link_count, 32'h1);
    wr(`TGR_IDX_CTRL, 32'h00000000);
    wr(`TGR_IDX_CTRL, 32'h00000029);
    repeat (300) @(posedge clk_sys);
    chk(link_count, 32'h2);
  endtask : t_link_once

  // compare: A toggles pin A, unbuffered C with bit3 clear toggles pin A too
  task automatic t_compare;
    do_reset;
    wr(`TGR_IDX_CH0_A, 32'h00000020);
    wr(`TGR_IDX_CH0_C, 32'h00000060);
    wr(`TGR_IDX_CTRL, 32'h00000009);
    repeat (64) @(posedge clk_sys);
    chk({30'h0, pin_out[2], pin_out[0]}, 32'h1);
    chk({30'h0, pin_oe[2], pin_oe[0]}, 32'h1);
    repeat (64) @(posedge clk_sys);
    chk({30'h0, pin_out[2], pin_out[0]}, 32'h0);
    chk(link_count, 32'h1);
  endtask : t_compare

  // pwm: period 16, pin B active high from change point 3 to period end
  task automatic t_pwm;
    int high;
    do_reset;
    wr(`TGR_IDX_AUX, 32'h00000104);
    wr(`TGR_IDX_CH0_A, 32'h0000000F);
    wr(`TGR_IDX_CH0_B, 32'h00000003);
    wr(`TGR_IDX_CTRL, 32'h0000000A);
    repeat (40) @(posedge clk_sys);
    high = 0;
    repeat (160) begin
      @(posedge clk_sys);
      if (pin_out[1] === 1'b1) high++;
    end
    chk(high, 32'd120);
    chk({24'h0, pin_oe}, 32'h00000002);
  endtask : t_pwm

  // reset-synchronous pwm: period 16, change point 7, idle D register
  task automatic t_rspwm;
    int toggles;
    int skew;
    int high;
    int e0;
    logic last;
    do_reset;
    wr(`TGR_IDX_CH0_A, 32'h0000000F);
    wr(`TGR_IDX_CH0_B, 32'h00000007);
    wr(`TGR_IDX_CH0_D, 32'h00000003);
    wr(`TGR_IDX_CTRL, 32'h0000000B);
    repeat (40) @(posedge clk_sys);
    toggles = 0;
    skew = 0;
    high = 0;
    e0 = link_count;
    last = pin_out[2];
    repeat (160) begin
      @(posedge clk_sys);
      if (pin_out[2] !== last) toggles++;
      if (pin_out[1] === pin_out[3]) skew++;
      if (pin_out[1] === 1'b1) high++;
      last = pin_out[2];
    end
    chk(toggles, 32'd10);
    chk(skew, 32'd0);
    chk(high, 32'd80);
    chk(link_count - e0, 32'd10);
    chk({24'h0, pin_oe}, 32'h000000FE);
  endtask : t_rspwm

  initial begin
    do_reset;
    t_regs;
    t_capture;
    t_link_once;
    t_compare;
    t_pwm;
    t_rspwm;
    stop_test;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test;
    end
  end
endmodule : tgr_top_bench
`default_nettype wire
